//--- inc/dsu_pkg.sv
// constants, types and register map of the debug serial unit receive side
package dsu_pkg;

  // ==========================================================
  // register map (byte addresses on the register port)
  localparam logic [31:0] DSU_ADDR_FRAME_MODE = 32'h0B0001A4;
  localparam logic [31:0] DSU_ADDR_EXT_MODE   = 32'h0B0001A6;
  localparam logic [31:0] DSU_ADDR_RXB_WIDE   = 32'h0B0001A8;
  localparam logic [31:0] DSU_ADDR_RXB_NARROW = 32'h0B0001AA;
  localparam logic [31:0] DSU_ADDR_RX_STATUS  = 32'h0B0001B0;
  localparam logic [31:0] DSU_ADDR_INT_STATUS = 32'h0B0001C0;
  localparam logic [31:0] DSU_ADDR_INT_CLEAR  = 32'h0B0001C2;
  localparam logic [31:0] DSU_ADDR_INT_ENABLE = 32'h0B0001C4;

  // ==========================================================
  // field positions and reset values
  localparam int          DSU_MODE_FIXED_POS = 7;
  localparam int          DSU_MODE_RXE_POS   = 6;
  localparam int          DSU_MODE_PS_HI_POS = 5;
  localparam int          DSU_MODE_PS_LO_POS = 4;
  localparam int          DSU_MODE_CL_POS    = 3;
  localparam int          DSU_MODE_SL_POS    = 2;
  localparam int          DSU_EXT_EN_POS     = 0;
  localparam logic [15:0] DSU_MODE_RESET     = 16'h0080;
  localparam logic [15:0] DSU_RXB_RESET      = 16'h0000;
  localparam int          DSU_WIDE_BITS      = 9;
  localparam int          DSU_EXT_BIT_POS    = 8;

  // parity select encodings
  localparam logic [1:0]  DSU_PAR_EVEN = 2'h3;
  localparam logic [1:0]  DSU_PAR_ODD  = 2'h2;
  localparam logic [1:0]  DSU_PAR_ZERO = 2'h1;
  localparam logic [1:0]  DSU_PAR_NONE = 2'h0;

  // event bit positions in status, enable and clear registers
  localparam int          DSU_EV_DONE     = 0;
  localparam int          DSU_EV_PARITY   = 1;
  localparam int          DSU_EV_FRAMING  = 2;
  localparam int          DSU_EV_OVERRUN  = 3;
  localparam int          DSU_EV_W        = 4;

  // ==========================================================
  // timing
  localparam int          DSU_CLK_HZ   = 10000000;
  localparam int          DSU_BAUD_BPS = 115200;
  localparam int          DSU_BIT_CYC  = DSU_CLK_HZ / DSU_BAUD_BPS;
  localparam int          DSU_HALF_CYC = DSU_BIT_CYC / 2;
  localparam int          DSU_CNT_W    = 8;

  // ==========================================================
  // types
  typedef struct packed {
    logic       rx_en;
    logic [1:0] par_sel;
    logic       char8;
    logic       stop2;
    logic       ext_en;
  } dsu_mode_s;

  typedef struct packed {
    logic overrun;
    logic framing;
    logic parity;
    logic done;
  } dsu_event_s;

  typedef enum logic [2:0] {
    DSU_RX_IDLE,
    DSU_RX_START,
    DSU_RX_DATA,
    DSU_RX_EXT,
    DSU_RX_PARITY,
    DSU_RX_STOP
  } dsu_rx_state_e;

endpackage : dsu_pkg

//--- rtl/dsu_rx_config.sv
// debug serial unit: frame configuration, receiver and receive buffers
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
//
// Behaviour
// - receive only while receive enable set
// - parity select: even, odd, zero, none
// - char length bit picks 8 or 7
// - stop length bit picks two or one
// - mode bit 7 resets and reads one
// - other reserved bits read zero
// - extended enable bit, reset zero
// - extended mode adds ninth data bit
// - extended mode only with parity none
// - wide buffer bit 8 holds ninth
// - bit 8 zero without extended mode
// - bit 7 zero after 7-bit char
// - narrow buffer shows bits 7 to 0
// - buffers read-only, reset to zero
// - unread buffer overwritten, overrun flagged
// - flag parity and framing errors
module dsu_rx_config
  import dsu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [31:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        rx_line,
  output logic             irq
);

  // ==========================================================
  // declarations
  logic [15:0]            frame_mode_reg;
  logic                   ext_mode_reg;
  logic [8:0]             rx_buf_reg;
  dsu_event_s             rx_flags_reg;
  dsu_event_s             int_stat_reg;
  dsu_event_s             int_en_reg;
  logic                   unread_reg;
  logic [15:0]            rdata_reg;
  logic                   rvalid_reg;
  logic                   rx_s1_reg;
  logic                   rx_s2_reg;
  logic                   rx_s3_reg;
  logic                   rx_lvl_reg;
  dsu_rx_state_e          state_reg;
  logic [DSU_CNT_W-1:0]   cnt_reg;
  logic [3:0]             bit_idx_reg;
  logic [8:0]             shift_reg;
  logic                   par_bit_reg;
  logic                   stop_cnt_reg;
  logic                   stop_bad_reg;
  dsu_mode_s              mode;
  logic                   ext_active;
  logic [3:0]             data_bits;
  logic                   cnt_done;
  logic                   sample;
  logic                   frame_end;
  logic                   par_err;
  logic                   frame_err;
  logic                   wr_mode;
  logic                   wr_ext;
  logic                   wr_clr;
  logic                   wr_en;
  logic                   rd_buf;
  logic [15:0]            rd_mux;
  dsu_event_s             ev_now;

  localparam logic [DSU_CNT_W-1:0] BIT_CNT  = DSU_CNT_W'(DSU_BIT_CYC - 1);
  localparam logic [DSU_CNT_W-1:0] HALF_CNT = DSU_CNT_W'(DSU_HALF_CYC - 1);

  // ==========================================================
  // mode decode
  // the mode register is not shadowed: changing it mid-frame gives
  // undefined framing, which software must avoid
  always_comb begin
    mode.rx_en   = frame_mode_reg[DSU_MODE_RXE_POS];
    mode.par_sel = frame_mode_reg[DSU_MODE_PS_HI_POS:DSU_MODE_PS_LO_POS];
    mode.char8   = frame_mode_reg[DSU_MODE_CL_POS];
    mode.stop2   = frame_mode_reg[DSU_MODE_SL_POS];
    mode.ext_en  = ext_mode_reg;
  end

  // ninth bit only when parity is off
  assign ext_active = mode.ext_en && (mode.par_sel == DSU_PAR_NONE);
  assign data_bits  = mode.char8 ? 4'h8 : 4'h7;

  // ==========================================================
  // register port decode
  assign wr_mode = reg_wr && (reg_addr == DSU_ADDR_FRAME_MODE);
  assign wr_ext  = reg_wr && (reg_addr == DSU_ADDR_EXT_MODE);
  assign wr_clr  = reg_wr && (reg_addr == DSU_ADDR_INT_CLEAR);
  assign wr_en   = reg_wr && (reg_addr == DSU_ADDR_INT_ENABLE);
  assign rd_buf  = reg_rd && ((reg_addr == DSU_ADDR_RXB_WIDE) ||
                              (reg_addr == DSU_ADDR_RXB_NARROW));

  // frame mode: only the documented fields are writable
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      frame_mode_reg <= DSU_MODE_RESET;
    end else if (wr_mode) begin
      frame_mode_reg <= (reg_wdata & 16'h007C) | DSU_MODE_RESET;
    end
  end

  // extended mode enable, resets off
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ext_mode_reg <= 1'b0;
    end else if (wr_ext) begin
      ext_mode_reg <= reg_wdata[DSU_EXT_EN_POS];
    end
  end

  // interrupt enable register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      int_en_reg <= '0;
    end else if (wr_en) begin
      int_en_reg <= dsu_event_s'(reg_wdata[DSU_EV_W-1:0]);
    end
  end

  // ==========================================================
  // read path: address decode, data valid in the next cycle only
  always_comb begin
    rd_mux = 16'h0000;
    if (reg_addr == DSU_ADDR_FRAME_MODE) begin
      rd_mux = frame_mode_reg;
    end else if (reg_addr == DSU_ADDR_EXT_MODE) begin
      rd_mux = {15'h0000, ext_mode_reg};
    end else if (reg_addr == DSU_ADDR_RXB_WIDE) begin
      rd_mux = {7'h00, rx_buf_reg};
    end else if (reg_addr == DSU_ADDR_RXB_NARROW) begin
      rd_mux = {8'h00, rx_buf_reg[7:0]};
    end else if (reg_addr == DSU_ADDR_RX_STATUS) begin
      rd_mux = {12'h000, rx_flags_reg};
    end else if (reg_addr == DSU_ADDR_INT_STATUS) begin
      rd_mux = {12'h000, int_stat_reg};
    end else if (reg_addr == DSU_ADDR_INT_ENABLE) begin
      rd_mux = {12'h000, int_en_reg};
    end else begin
      rd_mux = 16'h0000; // unmapped and write-only read as zero
    end
  end

  // capture the read answer
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= reg_rd ? rd_mux : 16'h0000;
      rvalid_reg <= reg_rd;
    end
  end

  // zero outside the answer cycle so a stale value is never seen
  assign reg_rdata = rvalid_reg ? rdata_reg : 16'h0000;

  // ==========================================================
  // line synchroniser: three stages, accept when stages two and
  // three agree, so a single-cycle glitch never reaches the receiver
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_s3_reg <= 1'b1;
    end else begin
      rx_s1_reg <= rx_line;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
    end
  end

  // filtered line level, idles high
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_lvl_reg <= 1'b1;
    end else if (rx_s2_reg == rx_s3_reg) begin
      rx_lvl_reg <= rx_s3_reg;
    end
  end

  // ==========================================================
  // bit timer
  assign cnt_done = (cnt_reg == '0);
  assign sample   = cnt_done && (state_reg != DSU_RX_IDLE);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else if (state_reg == DSU_RX_IDLE) begin
      cnt_reg <= HALF_CNT; // first sample lands mid start bit
    end else if (cnt_done) begin
      cnt_reg <= BIT_CNT;
    end else begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // ==========================================================
  // receive sequencer
  // disabling reception drops a frame in progress at once
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= DSU_RX_IDLE;
    end else if (!mode.rx_en) begin
      state_reg <= DSU_RX_IDLE;
    end else begin
      case (state_reg)
        DSU_RX_IDLE: begin
          if (!rx_lvl_reg) begin
            state_reg <= DSU_RX_START;
          end
        end
        DSU_RX_START: begin
          if (sample) begin
            // a start bit gone high by mid bit is noise
            state_reg <= rx_lvl_reg ? DSU_RX_IDLE : DSU_RX_DATA;
          end
        end
        DSU_RX_DATA: begin
          if (sample && (bit_idx_reg == data_bits - 4'h1)) begin
            if (ext_active) begin
              state_reg <= DSU_RX_EXT;
            end else if (mode.par_sel != DSU_PAR_NONE) begin
              state_reg <= DSU_RX_PARITY;
            end else begin
              state_reg <= DSU_RX_STOP;
            end
          end
        end
        DSU_RX_EXT: begin
          if (sample) begin
            state_reg <= DSU_RX_STOP;
          end
        end
        DSU_RX_PARITY: begin
          if (sample) begin
            state_reg <= DSU_RX_STOP;
          end
        end
        DSU_RX_STOP: begin
          if (frame_end) begin
            state_reg <= DSU_RX_IDLE;
          end
        end
        default: begin
          state_reg <= DSU_RX_IDLE;
        end
      endcase
    end
  end

  // data bit index, counts from the first data bit
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bit_idx_reg <= 4'h0;
    end else if (state_reg != DSU_RX_DATA) begin
      bit_idx_reg <= 4'h0;
    end else if (sample) begin
      bit_idx_reg <= bit_idx_reg + 4'h1;
    end
  end

  // assemble the character lsb first; unused upper bits stay zero
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      shift_reg <= '0;
    end else if (state_reg == DSU_RX_START) begin
      shift_reg <= '0;
    end else if (sample && (state_reg == DSU_RX_DATA)) begin
      shift_reg[bit_idx_reg[2:0]] <= rx_lvl_reg;
    end else if (sample && (state_reg == DSU_RX_EXT)) begin
      shift_reg[DSU_EXT_BIT_POS] <= rx_lvl_reg;
    end
  end

  // received parity bit
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      par_bit_reg <= 1'b0;
    end else if (sample && (state_reg == DSU_RX_PARITY)) begin
      par_bit_reg <= rx_lvl_reg;
    end
  end

  // stop bit counting; every stop bit must be high
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stop_cnt_reg <= 1'b0;
      stop_bad_reg <= 1'b0;
    end else if (state_reg != DSU_RX_STOP) begin
      stop_cnt_reg <= 1'b0;
      stop_bad_reg <= 1'b0;
    end else if (sample) begin
      stop_cnt_reg <= 1'b1;
      stop_bad_reg <= stop_bad_reg | !rx_lvl_reg;
    end
  end

  // frame ends at the last stop bit sample
  assign frame_end = sample && (state_reg == DSU_RX_STOP) &&
                     (!mode.stop2 || stop_cnt_reg);

  // ==========================================================
  // error checks at frame end
  always_comb begin
    case (mode.par_sel)
      DSU_PAR_EVEN: par_err = ^{shift_reg[7:0], par_bit_reg};
      DSU_PAR_ODD:  par_err = ~^{shift_reg[7:0], par_bit_reg};
      default:      par_err = 1'b0; // zero-parity and none ignore it
    endcase
  end

  assign frame_err = stop_bad_reg | !rx_lvl_reg;

  always_comb begin
    ev_now.done    = frame_end;
    ev_now.parity  = frame_end && par_err;
    ev_now.framing = frame_end && frame_err;
    ev_now.overrun = frame_end && unread_reg;
  end

  // ==========================================================
  // receive buffer: overwritten even when unread
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_buf_reg <= DSU_RXB_RESET[8:0];
    end else if (frame_end) begin
      rx_buf_reg <= shift_reg;
    end
  end

  // unread marker; a new character wins over a same-cycle read
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      unread_reg <= 1'b0;
    end else if (frame_end) begin
      unread_reg <= 1'b1;
    end else if (rd_buf) begin
      unread_reg <= 1'b0;
    end
  end

  // error status of the last completed character
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_flags_reg <= '0;
    end else if (frame_end) begin
      rx_flags_reg <= ev_now;
    end
  end

  // ==========================================================
  // interrupt: sticky status, write-one clear, set beats clear
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      int_stat_reg <= '0;
    end else begin
      int_stat_reg <= ev_now |
                      (int_stat_reg & ~(wr_clr ?
                        dsu_event_s'(reg_wdata[DSU_EV_W-1:0]) : dsu_event_s'('0)));
    end
  end

  // level output while any enabled event is pending
  assign irq = |(int_stat_reg & int_en_reg);

endmodule : dsu_rx_config

//--- testbench/dsu_rx_checker.sv
// assertion checker for the debug serial unit register port
`timescale 1ns/100ps
module dsu_rx_checker
  import dsu_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [31:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        rx_line,
  input wire logic        irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // helpers
  // write-only clear address counted as mapped, its read value is not fixed
  logic addr_mapped;
  assign addr_mapped = reg_addr inside {DSU_ADDR_FRAME_MODE, DSU_ADDR_EXT_MODE,
    DSU_ADDR_RXB_WIDE, DSU_ADDR_RXB_NARROW, DSU_ADDR_RX_STATUS, DSU_ADDR_INT_STATUS,
    DSU_ADDR_INT_CLEAR, DSU_ADDR_INT_ENABLE};

  // ==========================================================
  // read data of the mode, extended mode and buffer registers and of unmapped places, and the interrupt with all enables off
  a_mode_fixed_one: assert property (
    $past(reg_rd) && $past(reg_addr) == DSU_ADDR_FRAME_MODE |-> reg_rdata[7])
    else $error("mode bit 7 read as zero");
  a_mode_reserved_zero: assert property (
    $past(reg_rd) && $past(reg_addr) == DSU_ADDR_FRAME_MODE
    |-> reg_rdata[15:8] == 8'h00 && reg_rdata[1:0] == 2'h0)
    else $error("mode reserved bits not zero");
  a_mode_write_back: assert property (
    $past(reg_rd) && $past(reg_addr) == DSU_ADDR_FRAME_MODE && !$past(reg_wr, 2)
    && $past(reg_wr, 3) && $past(reg_addr, 3) == DSU_ADDR_FRAME_MODE
    |-> reg_rdata == (($past(reg_wdata, 3) & 16'h007C) | 16'h0080))
    else $error("mode readback differs from write");
  a_ext_reserved_zero: assert property (
    $past(reg_rd) && $past(reg_addr) == DSU_ADDR_EXT_MODE |-> reg_rdata[15:1] == 15'h0000)
    else $error("ext mode reserved bits not zero");
  a_wide_upper_zero: assert property (
    $past(reg_rd) && $past(reg_addr) == DSU_ADDR_RXB_WIDE |-> reg_rdata[15:9] == 7'h00)
    else $error("wide buffer upper bits not zero");
  a_narrow_upper_zero: assert property (
    $past(reg_rd) && $past(reg_addr) == DSU_ADDR_RXB_NARROW |-> reg_rdata[15:8] == 8'h00)
    else $error("narrow buffer upper bits not zero");
  a_narrow_matches_wide: assert property (
    $past(reg_rd) && $past(reg_addr) == DSU_ADDR_RXB_NARROW
    && $past(reg_rd, 3) && $past(reg_addr, 3) == DSU_ADDR_RXB_WIDE
    |-> reg_rdata[7:0] == $past(reg_rdata[7:0], 2))
    else $error("narrow buffer differs from wide");
  a_unmapped_zero: assert property (
    $past(reg_rd) && !$past(addr_mapped) |-> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_irq_needs_enable: assert property (
    $past(reg_rd) && $past(reg_addr) == DSU_ADDR_INT_ENABLE && reg_rdata[3:0] == 4'h0
    |-> !irq)
    else $error("interrupt high with all enables off");

  // ==========================================================
  // main scenarios reached
  c_irq_rise: cover property ($rose(irq));
  c_ninth_bit: cover property ($past(reg_rd) && $past(reg_addr) == DSU_ADDR_RXB_WIDE
    && reg_rdata[8]);
  c_line_start: cover property ($fell(rx_line));
endmodule : dsu_rx_checker

bind dsu_rx_config dsu_rx_checker u_dsu_rx_checker (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_line(rx_line), .irq(irq));

//--- testbench/dsu_host_model.sv
// serial host model driving the receive line of the debug serial unit
`timescale 1ns/100ps
module dsu_host_model
  import dsu_pkg::*;
(
  input  wire logic clk_sys,
  output logic      rx_line
);
  // idle high, as the pulled-up line rests between frames
  initial rx_line = 1'b1;

  // ==========================================================
  // one bit time per element, changed just after a clock edge
  task automatic put(input logic b);
    rx_line <= b;
    repeat (DSU_BIT_CYC) @(posedge clk_sys);
  endtask : put

  // bad_par and bad_stop break the frame on purpose for error scenarios
  task automatic send(input logic [8:0] d, input dsu_mode_s m, input logic bad_par,
                      input logic bad_stop);
    int         n;
    logic [7:0] v;
    logic       p;
    n = m.char8 ? 8 : 7;
    v = m.char8 ? d[7:0] : {1'b0, d[6:0]};
    p = (m.par_sel == DSU_PAR_EVEN) ? ^v : (m.par_sel == DSU_PAR_ODD) ? ~^v : 1'b0;
    p = p ^ bad_par;
    @(posedge clk_sys);
    put(1'b0);
    for (int i = 0; i < n; i++) put(d[i]);
    if (m.par_sel == DSU_PAR_NONE && m.ext_en) put(d[8]);
    else if (m.par_sel != DSU_PAR_NONE) put(p);
    if (m.stop2) put(1'b1);
    put(~bad_stop);
    repeat (2) put(1'b1);
  endtask : send
endmodule : dsu_host_model

//--- testbench/dsu_rx_config_tb.sv
// self-checking testbench of the debug serial unit receive side
`timescale 1ns/100ps
module dsu_rx_config_tb
  import dsu_pkg::*;
;
  logic        clk_sys   = 1'b0;
  logic        sys_rst   = 1'b1;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_addr  = 32'h00000000;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [15:0] rd_val;
  logic        rx_line;
  logic        irq;
  int          n_mismatch = 0;
  int          n_compared = 0;
  // frame table: mode, sent data, expected wide buffer, {bad parity, bad stop}, status
  dsu_mode_s   f_mode [7];
  logic [8:0]  f_data [7];
  logic [15:0] f_wide [7];
  logic [1:0]  f_err  [7];
  logic [3:0]  f_stat [7];

  always #50 clk_sys = ~clk_sys;

  dsu_rx_config u_dsu_rx_config (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_line(rx_line), .irq(irq));
  dsu_host_model u_dsu_host_model (.clk_sys(clk_sys), .rx_line(rx_line));

  // ==========================================================
  // register port tasks: one-cycle strobes, read data in the next cycle only
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [31:0] a, input logic [15:0] exp);
    rd(a);
    chk(rd_val, exp);
  endtask : rdchk

  function automatic logic [15:0] mode_word(input dsu_mode_s m);
    return {8'h00, 1'b1, m.rx_en, m.par_sel, m.char8, m.stop2, 2'b00};
  endfunction : mode_word

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  // ==========================================================
  // watchdog: eleven frames of some 1200 cycles each fit well inside
  initial begin
    repeat (30000) @(posedge clk_sys);
    n_mismatch++;
    $display("[ERR] %0t: watchdog expired", $time);
    finish_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    f_mode = '{'{1'b1,2'h3,1'b1,1'b0,1'b0}, '{1'b1,2'h2,1'b0,1'b1,1'b0},
               '{1'b1,2'h1,1'b1,1'b0,1'b1}, '{1'b1,2'h0,1'b1,1'b0,1'b1},
               '{1'b1,2'h3,1'b1,1'b0,1'b0}, '{1'b1,2'h2,1'b1,1'b1,1'b0},
               '{1'b1,2'h0,1'b0,1'b0,1'b0}};
    f_data = '{9'h0A5, 9'h0FF, 9'h13C, 9'h15A, 9'h0C3, 9'h081, 9'h1D5};
    f_wide = '{16'h00A5, 16'h007F, 16'h003C, 16'h015A, 16'h00C3, 16'h0081, 16'h0055};
    f_err  = '{2'h0, 2'h0, 2'h2, 2'h0, 2'h2, 2'h1, 2'h0};
    f_stat = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h3, 4'h5, 4'h1};
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // reset values, reserved bits and read-only places
    rdchk(DSU_ADDR_FRAME_MODE, 16'h0080);
    rdchk(DSU_ADDR_EXT_MODE, 16'h0000);
    rdchk(DSU_ADDR_RXB_WIDE, 16'h0000);
    rdchk(DSU_ADDR_RXB_NARROW, 16'h0000);
    rdchk(32'h0B0001A0, 16'h0000);
    wr(DSU_ADDR_FRAME_MODE, 16'hFFFF);
    rdchk(DSU_ADDR_FRAME_MODE, 16'h00FC);
    wr(DSU_ADDR_EXT_MODE, 16'hFFFF);
    rdchk(DSU_ADDR_EXT_MODE, 16'h0001);
    wr(DSU_ADDR_RXB_WIDE, 16'hFFFF);
    rdchk(DSU_ADDR_RXB_WIDE, 16'h0000);
    wr(DSU_ADDR_FRAME_MODE, 16'h0000);
    rdchk(DSU_ADDR_FRAME_MODE, 16'h0080);
    $display("test registers done");
    // every parity mode, both lengths, both stop counts, ninth bit, errors
    wr(DSU_ADDR_INT_ENABLE, 16'h000F);
    for (int i = 0; i < 7; i++) begin
      wr(DSU_ADDR_FRAME_MODE, mode_word(f_mode[i]));
      rdchk(DSU_ADDR_FRAME_MODE, mode_word(f_mode[i]));
      wr(DSU_ADDR_EXT_MODE, {15'h0000, f_mode[i].ext_en});
      u_dsu_host_model.send(f_data[i], f_mode[i], f_err[i][1], f_err[i][0]);
      rdchk(DSU_ADDR_RX_STATUS, {12'h000, f_stat[i]});
      chk({15'h0000, irq}, 16'h0001);
      rdchk(DSU_ADDR_RXB_WIDE, f_wide[i]);
      rdchk(DSU_ADDR_RXB_NARROW, {8'h00, f_wide[i][7:0]});
      wr(DSU_ADDR_INT_CLEAR, 16'h000F);
      rdchk(DSU_ADDR_INT_STATUS, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
    end
    $display("test frames done");
    // two characters with no read between: the second overwrites the first
    u_dsu_host_model.send(9'h011, f_mode[6], 1'b0, 1'b0);
    u_dsu_host_model.send(9'h022, f_mode[6], 1'b0, 1'b0);
    rdchk(DSU_ADDR_RX_STATUS, 16'h0009);
    rdchk(DSU_ADDR_RXB_WIDE, 16'h0022);
    wr(DSU_ADDR_INT_CLEAR, 16'h000F);
    $display("test overrun done");
    // masked event stays sticky but keeps the interrupt low
    wr(DSU_ADDR_INT_ENABLE, 16'h0000);
    u_dsu_host_model.send(9'h033, f_mode[6], 1'b0, 1'b0);
    rdchk(DSU_ADDR_INT_ENABLE, 16'h0000);
    rdchk(DSU_ADDR_INT_STATUS, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    wr(DSU_ADDR_INT_CLEAR, 16'h000F);
    $display("test masked done");
    // receiver off: the line is ignored and the buffer keeps its character
    wr(DSU_ADDR_FRAME_MODE, 16'h0080);
    u_dsu_host_model.send(9'h044, f_mode[6], 1'b0, 1'b0);
    rdchk(DSU_ADDR_INT_STATUS, 16'h0000);
    rdchk(DSU_ADDR_RXB_WIDE, 16'h0033);
    $display("test disable done");
    finish_test();
  end
endmodule : dsu_rx_config_tb
